// file: rtl/jcp_pkg.sv
// jitter cleaner configuration bank: shared constants and carrier types
// assumes a host on a three-wire serial port, 32-bit words, address low
// Summary of operation
// (RQ1) loop1 reference divide, 14 bits at reg 27 [19:6], default 96
// (RQ2) loop1 feedback divide, 14 bits at reg 28 [19:6], default 192
// (RQ3) loop2 reference divide, 12 bits at reg 28 [31:20], default 4
// (RQ4) loop2 feedback divide, 18 bits at reg 30 [22:5], default 48
// (RQ5) loop2 prescaler at reg 30 [26:24], range 2 to 8, default 2
// (RQ6) host writes the calibration copy equal to loop2 feedback divide
// (RQ7) loop1 lock only after count from reg 25 [19:6] valid cycles
// (RQ8) loop2 lock only after count from reg 26 [19:6] in-window cycles
// (RQ9) loop1 lock window code at reg 24 [7:6], default 3
// (RQ10) dac update clock is loop1 detector rate divided by reg 25 [31:22]
// (RQ11) reg 26 bit 29 doubles loop2 reference, default off
// (RQ12) reg 29 bit 23 permits loop2 detector above 100 MHz, default on
// (RQ13) loop2 pump polarity reg 26 bit 28, gain [27:26] default 3
// (RQ14) loop1 pump polarity reg 27 bit 28 default 1, gain default 0
// (RQ15) pumps active while tristate bit 5 of reg 26 / 27 is zero
// (RQ16) three reference predivide selects in reg 27, input0 at [21:20]
// (RQ17) loop1 feedback delay reg 24 [14:12], reference delay [10:8]
// (RQ18) readback returns register chosen by reg 31 [20:16], level bit 21
// (RQ19) reg 31 bit 5 refuses writes to registers 0 through 30
// (RQ20) registers 0 to 5 control outputs 0 to 5 with same layout
// (RQ21) soft reset only in reg 0, global powerdown only in reg 1
// (RQ22) bit 31 of an output register powers down that output path
// (RQ23) only outputs 3 and 4 may take the oscillator input source
// (RQ24) reg 0 reset bit reloads defaults, clears on any later write
// (RQ25) reg 1 bit 17 places the whole device in powerdown
// (RQ26) regs 3 and 4 bit 30: 0 vco path, 1 oscillator input
// (RQ27) the write lock never blocks writes to register 31
// (RQ28) lock counters restart and lock drops when error leaves window
package jcp_pkg;
    // ****************************************************************
    // register map
    // ****************************************************************
    localparam int            JCP_SLOTS    = 14;
    localparam logic [4:0]    JCP_ADDR_OUT_LAST = 5'h05;
    localparam logic [4:0]    JCP_ADDR_24  = 5'h18;
    localparam logic [4:0]    JCP_ADDR_25  = 5'h19;
    localparam logic [4:0]    JCP_ADDR_26  = 5'h1a;
    localparam logic [4:0]    JCP_ADDR_27  = 5'h1b;
    localparam logic [4:0]    JCP_ADDR_28  = 5'h1c;
    localparam logic [4:0]    JCP_ADDR_29  = 5'h1d;
    localparam logic [4:0]    JCP_ADDR_30  = 5'h1e;
    localparam logic [4:0]    JCP_ADDR_31  = 5'h1f;
    // slot of register 24; outputs occupy slots 0 to 5
    localparam logic [3:0]    JCP_SLOT_24  = 4'h6;

    // reset values, slot order 0..5 then 24..31
    localparam logic [31:0]   JCP_OUT_DEF  = 32'h0000_0000;
    localparam logic [31:0]   JCP_DEF_24   = 32'h0000_00c0;
    localparam logic [31:0]   JCP_DEF_25   = 32'h0101_0000;
    localparam logic [31:0]   JCP_DEF_26   = 32'h0c08_0000;
    localparam logic [31:0]   JCP_DEF_27   = 32'h1000_1800;
    localparam logic [31:0]   JCP_DEF_28   = 32'h0040_3000;
    localparam logic [31:0]   JCP_DEF_29   = 32'h0780_0600;
    localparam logic [31:0]   JCP_DEF_30   = 32'h0200_0600;
    localparam logic [31:0]   JCP_DEF_31   = 32'h001f_0000;
    localparam logic [31:0]   JCP_ADDR_MASK = 32'h0000_001f;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int JCP_B_PATH_PD    = 31;
    localparam int JCP_B_SRC_OSC    = 30;
    localparam int JCP_B_SPECIAL    = 17;
    localparam int JCP_B_DOUBLER    = 29;
    localparam int JCP_B_PUMP_POL   = 28;
    localparam int JCP_B_PUMP_GAIN  = 26;
    localparam int JCP_B_TRISTATE   = 5;
    localparam int JCP_B_FAST_RATE  = 23;
    localparam int JCP_B_OSC_RANGE  = 24;
    localparam int JCP_B_WIN        = 6;
    localparam int JCP_B_WIN2       = 30;
    localparam int JCP_B_R_DLY      = 8;
    localparam int JCP_B_N_DLY      = 12;
    localparam int JCP_B_DAC_DIV    = 22;
    localparam int JCP_B_CNT        = 6;
    localparam int JCP_B_DIV14      = 6;
    localparam int JCP_B_PRE0       = 20;
    localparam int JCP_B_PRE1       = 22;
    localparam int JCP_B_PRE2       = 24;
    localparam int JCP_B_L2_R       = 20;
    localparam int JCP_B_L2_N       = 5;
    localparam int JCP_B_PRESCALE   = 24;
    localparam int JCP_B_RB_LEVEL   = 21;
    localparam int JCP_B_RB_ADDR    = 16;
    localparam int JCP_B_WLOCK      = 5;
    localparam int JCP_OSC_OUT_A    = 3;
    localparam int JCP_OSC_OUT_B    = 4;
    localparam int JCP_OUTPUTS      = 6;

    // ****************************************************************
    // carrier types
    // ****************************************************************
    typedef struct packed {
        logic [13:0] ref_divide;
        logic [13:0] feedback_divide;
        logic        pump_polarity;
        logic [1:0]  pump_gain;
        logic        pump_active;
        logic [1:0]  ref_input0_predivide;
        logic [1:0]  ref_input1_predivide;
        logic [1:0]  ref_input2_predivide;
        logic [2:0]  feedback_delay;
        logic [2:0]  reference_delay;
        logic [1:0]  lock_window;
        logic [13:0] lock_count;
        logic [9:0]  dac_divide;
    } jcp_loop1_cfg_t;

    typedef struct packed {
        logic [11:0] ref_divide;
        logic [17:0] feedback_divide;
        logic [2:0]  prescaler;
        logic [17:0] feedback_cal_copy;
        logic [1:0]  lock_window;
        logic        ref_doubler_on;
        logic        pump_polarity;
        logic [1:0]  pump_gain;
        logic        pump_active;
        logic        high_rate_detector;
        logic [2:0]  oscillator_range;
        logic [13:0] lock_count;
    } jcp_loop2_cfg_t;

    typedef struct packed {
        logic [5:0]  path_on;
        logic [5:0]  from_oscillator;
    } jcp_output_cfg_t;

    typedef enum logic [3:0] {
        SP_IDLE   = 4'b0001,
        SP_SHIFT  = 4'b0010,
        SP_COMMIT = 4'b0100,
        SP_LOAD   = 4'b1000
    } jcp_port_state_t;
endpackage : jcp_pkg

// file: rtl/jcp_lock_counter.sv
// digital lock detect counter for one loop
// assumes one-cycle detector tick pulses and a synchronous window flag
`timescale 1ns/100ps
module jcp_lock_counter
    import jcp_pkg::*;
(
    // clock and reset
    input  wire logic        mclk_in,
    input  wire logic        rstn_in,
    // detector status
    input  wire logic        tick_in,
    input  wire logic        in_window_in,
    input  wire logic [13:0] target_in,
    // lock indication
    output logic             locked_out
);
    import jcp_pkg::*;

    logic [13:0] count_reg;

    // count in-window detector cycles, restart on leaving the window
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            count_reg <= 14'h0000;
        end else if (!in_window_in) begin
            count_reg <= 14'h0000; // RQ28
        end else if (tick_in && (count_reg < target_in)) begin
            count_reg <= count_reg + 14'h0001;
        end
    end

    // lock only once the programmed count has been reached
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            locked_out <= 1'b0;
        end else begin
            locked_out <= in_window_in && (count_reg >= target_in); // RQ7 RQ8
        end
    end
endmodule : jcp_lock_counter

// file: rtl/jcp_config_bank.sv
// jitter cleaner configuration bank with serial programming port
// assumes serial pins already synchronous to mclk_in and slower than it
`timescale 1ns/100ps
module jcp_config_bank
    import jcp_pkg::*;
(
    // clock and reset
    input  wire logic            mclk_in,
    input  wire logic            rstn_in,
    // serial programming port
    input  wire logic            serial_clk_in,
    input  wire logic            serial_data_in,
    input  wire logic            serial_latch_enable_in,
    output logic                 readback_data_out,
    // loop detector status
    input  wire logic            loop1_pd_tick_in,
    input  wire logic            loop1_in_window_in,
    input  wire logic            loop2_pd_tick_in,
    input  wire logic            loop2_in_window_in,
    // decoded configuration
    output jcp_pkg::jcp_loop1_cfg_t  loop1_cfg_out,
    output jcp_pkg::jcp_loop2_cfg_t  loop2_cfg_out,
    output jcp_pkg::jcp_output_cfg_t outputs_cfg_out,
    output logic                 device_powerdown_out,
    output logic                 soft_reset_out,
    // loop status
    output logic                 loop1_locked_out,
    output logic                 loop2_locked_out,
    output logic                 dac_update_out
);
    import jcp_pkg::*;

    // ****************************************************************
    // storage
    // ****************************************************************
    logic [31:0]     cfg_reg [JCP_SLOTS];
    logic [31:0]     shift_reg;
    logic [31:0]     readback_reg;
    logic            sclk_prev_reg;
    logic            le_prev_reg;
    logic            reset_flag_reg;
    logic [9:0]      dac_count_reg;
    logic            dac_pulse_reg;
    jcp_port_state_t state_reg;
    jcp_port_state_t state_next;

    logic            sclk_rise;
    logic            le_rise;
    logic [4:0]      word_addr;
    logic            addr_mapped;
    logic [3:0]      word_slot;
    logic            write_allowed;
    logic            soft_reset_hit;
    logic [4:0]      rb_addr;
    logic            rb_level;
    logic            rb_mapped;
    logic [3:0]      rb_slot;
    logic [31:0]     rb_word;

    // ****************************************************************
    // address decode
    // ****************************************************************

    // map a register number onto a storage slot
    function automatic logic [3:0] slot_of(input logic [4:0] addr);
        logic [4:0] rel;
        rel = addr - JCP_ADDR_24;
        if (addr <= JCP_ADDR_OUT_LAST) begin
            slot_of = addr[3:0]; // RQ20
        end else begin
            slot_of = JCP_SLOT_24 + {1'b0, rel[2:0]};
        end
    endfunction : slot_of

    // true for the registers this bank holds
    function automatic logic is_mapped(input logic [4:0] addr);
        is_mapped = (addr <= JCP_ADDR_OUT_LAST) || (addr >= JCP_ADDR_24);
    endfunction : is_mapped

    // default word of a slot
    function automatic logic [31:0] default_of(input logic [3:0] slot);
        case (slot)
            4'h6:    default_of = JCP_DEF_24;
            4'h7:    default_of = JCP_DEF_25;
            4'h8:    default_of = JCP_DEF_26;
            4'h9:    default_of = JCP_DEF_27;
            4'ha:    default_of = JCP_DEF_28;
            4'hb:    default_of = JCP_DEF_29;
            4'hc:    default_of = JCP_DEF_30;
            4'hd:    default_of = JCP_DEF_31;
            default: default_of = JCP_OUT_DEF;
        endcase
    endfunction : default_of

    // edges of the serial pins and the decoded incoming word
    always_comb begin
        sclk_rise   = serial_clk_in && !sclk_prev_reg;
        le_rise     = serial_latch_enable_in && !le_prev_reg;
        word_addr   = shift_reg[4:0];
        addr_mapped = is_mapped(word_addr);
        word_slot   = slot_of(word_addr);
    end

    // lock bit spares register 31 so it can always be released
    always_comb begin
        write_allowed = (word_addr == JCP_ADDR_31) // RQ27
            || !cfg_reg[JCP_SLOTS-1][JCP_B_WLOCK];   // RQ19
        soft_reset_hit = (word_addr == 5'h00)
            && shift_reg[JCP_B_SPECIAL];              // RQ21
    end

    // ****************************************************************
    // serial port sequencer
    // ****************************************************************

    // pin history for edge detection
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            sclk_prev_reg <= 1'b0;
            le_prev_reg   <= 1'b1;
        end else begin
            sclk_prev_reg <= serial_clk_in;
            le_prev_reg   <= serial_latch_enable_in;
        end
    end

    // shift while latch enable low, commit on its rising edge
    always_comb begin
        case (state_reg)
            SP_IDLE: begin
                state_next = serial_latch_enable_in ? SP_IDLE : SP_SHIFT;
            end
            SP_SHIFT: begin
                state_next = le_rise ? SP_COMMIT : SP_SHIFT;
            end
            SP_COMMIT: begin
                state_next = SP_LOAD;
            end
            SP_LOAD: begin
                state_next = SP_IDLE;
            end
            default: begin
                state_next = SP_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            state_reg <= SP_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // incoming bits, most significant first
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            shift_reg <= 32'h0000_0000;
        end else if (sclk_rise && !serial_latch_enable_in
                     && (state_reg == SP_SHIFT
                         || state_reg == SP_IDLE)) begin
            shift_reg <= {shift_reg[30:0], serial_data_in};
        end
    end

    // ****************************************************************
    // register writes
    // ****************************************************************

    // reset bit write reloads defaults and discards the rest of the word
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            for (int i = 0; i < JCP_SLOTS; i++) begin
                cfg_reg[i] <= default_of(4'(i));
            end
        end else if (state_reg == SP_COMMIT && write_allowed) begin
            if (soft_reset_hit) begin
                for (int i = 0; i < JCP_SLOTS; i++) begin
                    cfg_reg[i] <= default_of(4'(i)); // RQ24
                end
            end else if (addr_mapped) begin
                cfg_reg[word_slot] <= shift_reg & ~JCP_ADDR_MASK;
            end
        end
    end

    // reset indication stays until the next accepted write
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            reset_flag_reg <= 1'b0;
        end else if (state_reg == SP_COMMIT && write_allowed) begin
            reset_flag_reg <= soft_reset_hit; // RQ24
        end
    end

    // ****************************************************************
    // readback
    // ****************************************************************

    // selected register and required latch level
    always_comb begin
        rb_addr   = cfg_reg[JCP_SLOTS-1][JCP_B_RB_ADDR +: 5];  // RQ18
        rb_level  = cfg_reg[JCP_SLOTS-1][JCP_B_RB_LEVEL];      // RQ18
        rb_mapped = is_mapped(rb_addr);
        rb_slot   = slot_of(rb_addr);
        rb_word   = 32'h0000_0000;
        if (rb_mapped) begin
            rb_word = cfg_reg[rb_slot] | {27'h000_0000, rb_addr};
            if (rb_addr == 5'h00) begin
                rb_word[JCP_B_SPECIAL] = reset_flag_reg;
            end
        end
    end

    // load after each commit, shift out while latch at readback level
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            readback_reg <= 32'h0000_0000;
        end else if (state_reg == SP_LOAD) begin
            readback_reg <= rb_word; // RQ18
        end else if (sclk_rise && serial_latch_enable_in == rb_level) begin
            readback_reg <= {readback_reg[30:0], 1'b0};
        end
    end

    // serial data out
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            readback_data_out <= 1'b0;
        end else begin
            readback_data_out <= readback_reg[31];
        end
    end

    // ****************************************************************
    // decoded fields
    // ****************************************************************

    // first loop controls
    always_comb begin
        loop1_cfg_out.ref_divide      = cfg_reg[9][JCP_B_DIV14 +: 14];  // RQ1
        loop1_cfg_out.feedback_divide = cfg_reg[10][JCP_B_DIV14 +: 14]; // RQ2
        loop1_cfg_out.pump_polarity   = cfg_reg[9][JCP_B_PUMP_POL];     // RQ14
        loop1_cfg_out.pump_gain       = cfg_reg[9][JCP_B_PUMP_GAIN +: 2];
        loop1_cfg_out.pump_active     = !cfg_reg[9][JCP_B_TRISTATE];    // RQ15
        loop1_cfg_out.ref_input0_predivide = cfg_reg[9][JCP_B_PRE0 +: 2];
        loop1_cfg_out.ref_input1_predivide = cfg_reg[9][JCP_B_PRE1 +: 2];
        loop1_cfg_out.ref_input2_predivide = cfg_reg[9][JCP_B_PRE2 +: 2];
        loop1_cfg_out.feedback_delay  = cfg_reg[6][JCP_B_N_DLY +: 3];   // RQ17
        loop1_cfg_out.reference_delay = cfg_reg[6][JCP_B_R_DLY +: 3];   // RQ17
        loop1_cfg_out.lock_window     = cfg_reg[6][JCP_B_WIN +: 2];     // RQ9
        loop1_cfg_out.lock_count      = cfg_reg[7][JCP_B_CNT +: 14];
        loop1_cfg_out.dac_divide      = cfg_reg[7][JCP_B_DAC_DIV +: 10];
    end // RQ16

    // second loop controls
    always_comb begin
        loop2_cfg_out.ref_divide      = cfg_reg[10][JCP_B_L2_R +: 12]; // RQ3
        loop2_cfg_out.feedback_divide = cfg_reg[12][JCP_B_L2_N +: 18]; // RQ4
        loop2_cfg_out.prescaler       = cfg_reg[12][JCP_B_PRESCALE +: 3];
        loop2_cfg_out.feedback_cal_copy = cfg_reg[11][JCP_B_L2_N +: 18];
        loop2_cfg_out.lock_window     = cfg_reg[8][JCP_B_WIN2 +: 2];
        loop2_cfg_out.ref_doubler_on  = cfg_reg[8][JCP_B_DOUBLER];     // RQ11
        loop2_cfg_out.pump_polarity   = cfg_reg[8][JCP_B_PUMP_POL];    // RQ13
        loop2_cfg_out.pump_gain       = cfg_reg[8][JCP_B_PUMP_GAIN +: 2];
        loop2_cfg_out.pump_active     = !cfg_reg[8][JCP_B_TRISTATE];   // RQ15
        loop2_cfg_out.high_rate_detector = cfg_reg[11][JCP_B_FAST_RATE];
        loop2_cfg_out.oscillator_range = cfg_reg[11][JCP_B_OSC_RANGE +: 3];
        loop2_cfg_out.lock_count      = cfg_reg[8][JCP_B_CNT +: 14];
    end // RQ5 RQ12

    // device powerdown and output paths
    always_comb begin
        device_powerdown_out = cfg_reg[1][JCP_B_SPECIAL]; // RQ25
        soft_reset_out       = reset_flag_reg;
        for (int i = 0; i < JCP_OUTPUTS; i++) begin
            outputs_cfg_out.path_on[i] = !cfg_reg[i][JCP_B_PATH_PD]
                && !device_powerdown_out;                  // RQ22
            outputs_cfg_out.from_oscillator[i] = 1'b0;     // RQ23
        end
        outputs_cfg_out.from_oscillator[JCP_OSC_OUT_A] =
            cfg_reg[JCP_OSC_OUT_A][JCP_B_SRC_OSC];         // RQ26
        outputs_cfg_out.from_oscillator[JCP_OSC_OUT_B] =
            cfg_reg[JCP_OSC_OUT_B][JCP_B_SRC_OSC];         // RQ26
    end

    // ****************************************************************
    // lock detect and dac update clock
    // ****************************************************************

    // first loop lock detect
    jcp_lock_counter u_loop1_lock (
        .mclk_in      (mclk_in),
        .rstn_in      (rstn_in),
        .tick_in      (loop1_pd_tick_in),
        .in_window_in (loop1_in_window_in),
        .target_in    (loop1_cfg_out.lock_count),
        .locked_out   (loop1_locked_out)
    ); // RQ7

    // second loop lock detect
    jcp_lock_counter u_loop2_lock (
        .mclk_in      (mclk_in),
        .rstn_in      (rstn_in),
        .tick_in      (loop2_pd_tick_in),
        .in_window_in (loop2_in_window_in),
        .target_in    (loop2_cfg_out.lock_count),
        .locked_out   (loop2_locked_out)
    ); // RQ8

    // one pulse every dac_divide loop1 detector ticks, zero acts as one
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            dac_count_reg <= 10'h000;
            dac_pulse_reg <= 1'b0;
        end else if (loop1_pd_tick_in) begin
            if (dac_count_reg + 10'h001 >= loop1_cfg_out.dac_divide) begin
                dac_count_reg <= 10'h000; // RQ10
                dac_pulse_reg <= 1'b1;
            end else begin
                dac_count_reg <= dac_count_reg + 10'h001;
                dac_pulse_reg <= 1'b0;
            end
        end else begin
            dac_pulse_reg <= 1'b0;
        end
    end

    // dac update strobe
    always_comb begin
        dac_update_out = dac_pulse_reg;
    end
endmodule : jcp_config_bank

// file: test/jcp_checker_asserts.sv
// checker for the configuration bank, watching top level ports only
// assumes one clock domain with a synchronous active low reset
`timescale 1ns/100ps
module jcp_checker
    import jcp_pkg::*;
(
    // clock and reset
    input wire logic            mclk_in,
    input wire logic            rstn_in,
    // detector status
    input wire logic            loop1_pd_tick_in,
    input wire logic            loop1_in_window_in,
    input wire logic            loop2_in_window_in,
    // configuration and status
    input wire jcp_loop1_cfg_t  loop1_cfg_out,
    input wire jcp_loop2_cfg_t  loop2_cfg_out,
    input wire jcp_output_cfg_t outputs_cfg_out,
    input wire logic            device_powerdown_out,
    input wire logic            soft_reset_out,
    input wire logic            loop1_locked_out,
    input wire logic            loop2_locked_out,
    input wire logic            dac_update_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);
    AST_RST_DEF: assert property ($rose(rstn_in) |->
        loop1_cfg_out.ref_divide == 14'h0060 &&
        loop2_cfg_out.feedback_divide == 18'h0_0030)
        else $error("divider defaults wrong after reset");
    AST_SRST_DEF: assert property (
        soft_reset_out && $past(soft_reset_out) |->
        loop1_cfg_out.ref_divide == 14'h0060)
        else $error("defaults not held while reset flag set");
    AST_L1_DROP: assert property (
        !loop1_in_window_in |=> !loop1_locked_out)
        else $error("loop1 lock held outside window");
    AST_L2_DROP: assert property (
        !loop2_in_window_in |=> !loop2_locked_out)
        else $error("loop2 lock held outside window");
    AST_L1_ROSE: assert property (
        $rose(loop1_locked_out) |-> $past(loop1_in_window_in))
        else $error("loop1 lock rose without window");
    AST_L2_ROSE: assert property (
        $rose(loop2_locked_out) |-> $past(loop2_in_window_in))
        else $error("loop2 lock rose without window");
    AST_DAC: assert property (
        dac_update_out |-> $past(loop1_pd_tick_in))
        else $error("dac pulse without detector tick");
    AST_PD: assert property (
        device_powerdown_out |-> outputs_cfg_out.path_on == 6'h00)
        else $error("output path on in powerdown");
    AST_SRC: assert property (
        (outputs_cfg_out.from_oscillator & 6'h27) == 6'h00)
        else $error("oscillator source on wrong output");
endmodule : jcp_checker

bind jcp_config_bank jcp_checker u_chk (.mclk_in, .rstn_in,
    .loop1_pd_tick_in, .loop1_in_window_in, .loop2_in_window_in,
    .loop1_cfg_out, .loop2_cfg_out, .outputs_cfg_out,
    .device_powerdown_out, .soft_reset_out, .loop1_locked_out,
    .loop2_locked_out, .dac_update_out);

// file: test/jcp_host_model.sv
// host model driving the three-wire serial programming port
// assumes the caller starts each transfer right after a clock edge
`timescale 1ns/100ps
module jcp_host_model (
    // clock and readback
    input  wire logic mclk_in,
    input  wire logic rb_in,
    // serial pins
    output logic      sclk_out,
    output logic      sdata_out,
    output logic      le_out
);
    // idle pins: clock low, latch high
    initial begin
        sclk_out = 1'b0;
        sdata_out = 1'b0;
        le_out = 1'b1;
    end
    // one word msb first, readback bits gathered before each rise
    task automatic xfer(input logic [31:0] w, output logic [31:0] rb);
        @(posedge mclk_in) le_out <= 1'b0;
        for (int i = 31; i >= 0; i--) begin
            @(posedge mclk_in) sdata_out <= w[i];
            rb[i] = rb_in;
            @(posedge mclk_in) sclk_out <= 1'b1;
            repeat (2) @(posedge mclk_in);
            sclk_out <= 1'b0;
            repeat (2) @(posedge mclk_in);
        end
        le_out <= 1'b1;
        sdata_out <= ~w[0]; // released line shows no stale bit
        repeat (5) @(posedge mclk_in);
    endtask : xfer
endmodule : jcp_host_model

// file: test/testbench.sv
// testbench: programs the bank serially and checks decoded fields
// assumes the host model and the checker are compiled before it
`timescale 1ns/100ps
module testbench;
    import jcp_pkg::*;
    logic mclk_in, rstn_in, t1, w1, t2, w2, sclk, sdat, le, rb;
    logic pd, srst, lk1, lk2, dac;
    jcp_loop1_cfg_t  c1;
    jcp_loop2_cfg_t  c2;
    jcp_output_cfg_t oc;
    int err_count = 0, n_tests = 0, ndac = 0;
    logic [31:0] d[8];
    logic [4:0] a;
    jcp_config_bank dut (.mclk_in, .rstn_in, .serial_clk_in(sclk),
        .serial_data_in(sdat), .serial_latch_enable_in(le),
        .readback_data_out(rb), .loop1_pd_tick_in(t1),
        .loop1_in_window_in(w1), .loop2_pd_tick_in(t2),
        .loop2_in_window_in(w2), .loop1_cfg_out(c1), .loop2_cfg_out(c2),
        .outputs_cfg_out(oc), .device_powerdown_out(pd),
        .soft_reset_out(srst), .loop1_locked_out(lk1),
        .loop2_locked_out(lk2), .dac_update_out(dac));
    jcp_host_model host (.mclk_in, .rb_in(rb), .sclk_out(sclk),
        .sdata_out(sdat), .le_out(le));
    // 50 MHz clock
    initial begin
        mclk_in = 1'b0;
        forever #10 mclk_in = ~mclk_in;
    end
    // dac pulse count
    always @(posedge mclk_in) if (dac === 1'b1) ndac++;
    task automatic chk(input string n, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [31:0] w);
        logic [31:0] j;
        host.xfer(w, j);
    endtask : wr
    task automatic rd(input logic [4:0] r, input logic [31:0] e);
        logic [31:0] s, g;
        s = {10'h0, 1'b0, r, 11'h0, 5'h1f};
        host.xfer(s, g);
        host.xfer(s, g);
        chk("readback", e, g);
    endtask : rd
    task automatic tk(input int n);
        repeat (n) begin
            t1 <= 1'b1;
            t2 <= 1'b1;
            @(posedge mclk_in);
            t1 <= 1'b0;
            t2 <= 1'b0;
            repeat (2) @(posedge mclk_in);
        end
    endtask : tk
    task automatic summarize;
        $display("errors %0d checks %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : summarize
    // hang guard
    initial begin
        repeat (40000) @(posedge mclk_in);
        err_count++;
        summarize();
    end
    // main sequence
    initial begin
        {rstn_in, t1, w1, t2, w2} = 5'h00;
        d = '{JCP_DEF_24, JCP_DEF_25, JCP_DEF_26, JCP_DEF_27,
              JCP_DEF_28, JCP_DEF_29, JCP_DEF_30, JCP_DEF_31};
        repeat (20) @(posedge mclk_in);
        rstn_in <= 1'b1;
        @(posedge mclk_in);
        for (int i = 0; i < 14; i++) begin
            a = (i < 6) ? 5'(i) : 5'(i + 18);
            rd(a, (i < 6 ? JCP_OUT_DEF : d[i-6]) | 32'(a));
        end
        wr(32'h100f_ffdb);
        wr(32'h037f_fffe);
        wr(32'h07ff_fffd);
        chk("l1 ref", 32'h0000_3fff, 32'(c1.ref_divide));
        chk("l2 fb", 32'h0003_ffff, 32'(c2.feedback_divide));
        chk("l2 pre", 32'h0000_0003, 32'(c2.prescaler));
        wr(32'h8000_0003);
        wr(32'h4000_0004);
        wr(32'h4002_0002);
        chk("outs", 32'h0000_0dd0, 32'({pd, oc}));
        wr(32'h0002_0001);
        chk("powerdown", 32'h0000_1010, 32'({pd, oc}));
        wr(32'h0000_0001);
        wr(32'h0000_003f);
        wr(32'h0000_005b);
        wr(32'h0000_001f);
        chk("locked", 32'h0000_3fff, 32'(c1.ref_divide));
        wr(32'h0000_005b);
        chk("unlocked", 32'h0000_0001, 32'(c1.ref_divide));
        wr(32'h0000_0058);
        chk("window", 32'h0000_0001, 32'(c1.lock_window));
        wr(32'h0002_0000);
        chk("srst", 32'h0001_0060, {15'h0, srst, 2'h0, c1.ref_divide});
        wr(32'h0000_0002);
        chk("srst clr", 32'h0000_0000, 32'(srst));
        wr(32'h0080_00d9);
        wr(32'h0c00_009a);
        w1 <= 1'b1;
        w2 <= 1'b1;
        tk(2);
        chk("lock2", 32'h0000_0001, 32'({lk1, lk2}));
        tk(1);
        chk("lock1", 32'h0000_0003, 32'({lk1, lk2}));
        chk("dac", 32'h0000_0001, 32'(ndac));
        w1 <= 1'b0;
        w2 <= 1'b0;
        repeat (2) @(posedge mclk_in);
        chk("unlock", 32'h0000_0000, 32'({lk1, lk2}));
        summarize();
    end
endmodule : testbench
